// *** hdl/pfs_pkg.sv ***
package pfs_pkg;
  localparam logic [11:0] PFS_OFF_CONTROL = 12'h000;
  localparam logic [11:0] PFS_OFF_KEY = 12'h004;
  localparam logic [11:0] PFS_OFF_PAGE = 12'h008;
  localparam logic [11:0] PFS_OFF_OFFSET = 12'h00C;
  localparam logic [11:0] PFS_OFF_TABLE_WRITE = 12'h010;
  localparam logic [11:0] PFS_OFF_STATUS = 12'h014;
  localparam int PFS_BIT_START = 15;
  localparam int PFS_BIT_FLASH_WRITE_ENABLE = 14;
  localparam int PFS_BIT_ERASE = 6;
  localparam logic [3:0] PFS_OP_ROW_PROGRAM = 4'h1;
  localparam logic [3:0] PFS_OP_PAGE_ERASE = 4'h2;
  localparam logic [7:0] PFS_KEY_FIRST = 8'h55;
  localparam logic [7:0] PFS_KEY_SECOND = 8'hAA;
  localparam logic [15:0] PFS_CONTROL_RESET = 16'h0000;
  localparam int PFS_ROW_WORDS = 64;
  localparam int PFS_PAGE_ROWS = 8;
  localparam int PFS_PAGE_WORDS = PFS_ROW_WORDS * PFS_PAGE_ROWS;
  localparam int PFS_ERASE_TIME_US = 20;
  localparam int PFS_PROGRAM_TIME_US = 2;
  localparam int PFS_CLK_MHZ = 20;
  localparam int PFS_ERASE_CYCLES = PFS_ERASE_TIME_US * PFS_CLK_MHZ;
  localparam int PFS_PROGRAM_CYCLES = PFS_PROGRAM_TIME_US * PFS_CLK_MHZ;

  typedef struct packed {
    logic req;
    logic erase;
    logic [15:0] addr;
    logic [23:0] data;
  } pfs_flash_s;
endpackage

// *** hdl/pfs_unlock.sv ***
`timescale 1ns/100ps
// tracks the two-write key sequence; any other register write breaks it
module pfs_unlock
  import pfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic key_wr,
  input wire logic other_wr,
  input wire logic [7:0] key_data,
  input wire logic consume,
  output logic armed
);
  logic [1:0] st_q;
  logic [1:0] st_d;

  always_comb
  begin
    st_d = st_q;
    if (consume || other_wr)
      st_d = 2'h0;
    else if (key_wr)
    begin
      if (key_data == PFS_KEY_FIRST)
        st_d = 2'h1;
      else if (key_data == PFS_KEY_SECOND && st_q == 2'h1)
        st_d = 2'h2;
      else
        st_d = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= 2'h0;
    else
      st_q <= st_d;
  end

  assign armed = (st_q == 2'h2);
endmodule

// *** hdl/pfs_sequencer.sv ***
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Behaviour
// - program one row per cycle; row write only into an erased page; here a cycle sends only PROGRAM_CYCLES words, 40 of the 64 by default
// - erase page spans eight rows, 512 instructions
// - erase page chosen by dummy table write at page pointer and offset; here offset bits 15:9 alone pick it
// - operation proceeds only after keys 0x55 then 0xAA
// - start bit 15 begins armed cycle and stalls the cpu
// - start bit clears itself when the cycle completes
// - latch buffer holds 64 instructions loaded by table writes
module pfs_sequencer
  import pfs_pkg::*;
#(
  parameter int ERASE_CYCLES = PFS_ERASE_CYCLES,
  parameter int PROGRAM_CYCLES = PFS_PROGRAM_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cpu_stall,
  output pfs_pkg::pfs_flash_s flash_out
);
  import pfs_pkg::*;

  typedef enum logic [2:0] {
    PFS_IDLE = 3'b001,
    PFS_ERASE = 3'b010,
    PFS_PROG = 3'b100
  } pfs_state_e;

  pfs_state_e st_q, st_d;
  logic [15:0] ctl_q, ctl_d;
  logic [15:0] page_q, page_d;
  logic [15:0] offs_q, offs_d;
  logic [15:0] erase_base_q, erase_base_d;
  logic erase_sel_q, erase_sel_d;
  logic [7:0] erased_q, erased_d;
  logic [15:0] cnt_q, cnt_d;
  logic [5:0] idx_q, idx_d;
  logic [23:0] latch_q [PFS_ROW_WORDS];
  logic [63:0] lvalid_q, lvalid_d;
  logic refused_q, refused_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic stall_q, stall_d;
  pfs_flash_s fl_q, fl_d;
  logic armed;
  logic setup, wr_acc, start_req, key_wr, other_wr, consume;

  function automatic logic [6:0] page_of(input logic [15:0] a);
    page_of = a[15:9];
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == PFS_OFF_CONTROL) || (a == PFS_OFF_KEY) || (a == PFS_OFF_PAGE) ||
             (a == PFS_OFF_OFFSET) || (a == PFS_OFF_TABLE_WRITE) || (a == PFS_OFF_STATUS);
  endfunction

  // no wait states: setup cycle decides, first access cycle completes
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready_q && pwrite && !pslverr_q;
  assign key_wr = wr_acc && paddr == PFS_OFF_KEY;
  assign other_wr = wr_acc && paddr != PFS_OFF_KEY && paddr != PFS_OFF_CONTROL;
  assign start_req = wr_acc && paddr == PFS_OFF_CONTROL && pwdata[PFS_BIT_START] &&
                     st_q == PFS_IDLE;
  assign consume = wr_acc && paddr == PFS_OFF_CONTROL;

  pfs_unlock u_unlock (
    .pclk(pclk),
    .presetn(presetn),
    .key_wr(key_wr),
    .other_wr(other_wr),
    .key_data(pwdata[7:0]),
    .consume(consume),
    .armed(armed)
  );

  always_comb
  begin
    st_d = st_q;
    ctl_d = ctl_q;
    page_d = page_q;
    offs_d = offs_q;
    erase_base_d = erase_base_q;
    erase_sel_d = erase_sel_q;
    erased_d = erased_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    lvalid_d = lvalid_q;
    refused_d = refused_q;
    fl_d = '0;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (setup && !pready_q)
    begin
      pready_d = 1'b1;
      pslverr_d = !mapped(paddr) || (pwrite && paddr == PFS_OFF_STATUS);
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        PFS_OFF_CONTROL: prdata_d = {16'h0000, ctl_q};
        PFS_OFF_PAGE: prdata_d = {16'h0000, page_q};
        PFS_OFF_OFFSET: prdata_d = {16'h0000, offs_q};
        PFS_OFF_STATUS: prdata_d = {22'h000000, refused_q, armed, erased_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (wr_acc)
    begin
      unique case (paddr)
        PFS_OFF_CONTROL:
        begin
          ctl_d = {ctl_q[PFS_BIT_START], pwdata[14:0]};
          if (start_req)
          begin
            ctl_d[PFS_BIT_START] = 1'b0;
            refused_d = 1'b1;
            if (armed && pwdata[PFS_BIT_FLASH_WRITE_ENABLE])
            begin
              if (pwdata[PFS_BIT_ERASE] && pwdata[3:0] == PFS_OP_PAGE_ERASE && erase_sel_q)
              begin
                ctl_d[PFS_BIT_START] = 1'b1;
                refused_d = 1'b0;
                st_d = PFS_ERASE;
                cnt_d = 16'(ERASE_CYCLES);
              end
              else if (!pwdata[PFS_BIT_ERASE] && pwdata[3:0] == PFS_OP_ROW_PROGRAM &&
                       erased_q[offs_q[8:6]] && page_of(offs_q) == page_of(erase_base_q))
              begin
                ctl_d[PFS_BIT_START] = 1'b1;
                refused_d = 1'b0;
                st_d = PFS_PROG;
                cnt_d = 16'(PROGRAM_CYCLES);
                idx_d = 6'h00;
              end
            end
          end
        end
        PFS_OFF_PAGE: page_d = pwdata[15:0];
        PFS_OFF_OFFSET: offs_d = pwdata[15:0];
        PFS_OFF_TABLE_WRITE:
        begin
          erase_base_d = {offs_q[15:9], 9'h000};
          erase_sel_d = 1'b1;
          lvalid_d[offs_q[5:0]] = 1'b1;
        end
        default: ;
      endcase
    end
    unique case (st_q)
      PFS_IDLE: ;
      PFS_ERASE:
      begin
        fl_d.req = (cnt_q == 16'(ERASE_CYCLES));
        fl_d.erase = 1'b1;
        fl_d.addr = erase_base_q;
        cnt_d = cnt_q - 16'h0001;
        if (cnt_q == 16'h0001)
        begin
          st_d = PFS_IDLE;
          ctl_d[PFS_BIT_START] = 1'b0;
          erased_d = 8'hFF;
          erase_sel_d = 1'b0;
        end
      end
      PFS_PROG:
      begin
        // row words streamed one per cycle while the PROGRAM_CYCLES count runs, which is the whole program delay; words past the count are not sent
        // a latch is released once sent, so the parked last index is never sent twice
        fl_d.req = lvalid_q[idx_q];
        fl_d.addr = {offs_q[15:6], idx_q};
        fl_d.data = latch_q[idx_q];
        lvalid_d[idx_q] = 1'b0;
        if (idx_q != 6'h3F)
          idx_d = idx_q + 6'h01;
        cnt_d = cnt_q - 16'h0001;
        if (cnt_q == 16'h0001)
        begin
          st_d = PFS_IDLE;
          ctl_d[PFS_BIT_START] = 1'b0;
          erased_d[offs_q[8:6]] = 1'b0;
          lvalid_d = '0;
        end
      end
      default: st_d = PFS_IDLE;
    endcase
    stall_d = (st_d != PFS_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= PFS_IDLE;
      ctl_q <= PFS_CONTROL_RESET;
      page_q <= 16'h0000;
      offs_q <= 16'h0000;
      erase_base_q <= 16'h0000;
      erase_sel_q <= 1'b0;
      erased_q <= 8'h00;
      cnt_q <= 16'h0000;
      idx_q <= 6'h00;
      lvalid_q <= '0;
      refused_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      stall_q <= 1'b0;
      fl_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      ctl_q <= ctl_d;
      page_q <= page_d;
      offs_q <= offs_d;
      erase_base_q <= erase_base_d;
      erase_sel_q <= erase_sel_d;
      erased_q <= erased_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      lvalid_q <= lvalid_d;
      refused_q <= refused_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      stall_q <= stall_d;
      fl_q <= fl_d;
    end
  end

  // latch array has no reset: contents only count where lvalid is set
  always_ff @(posedge pclk)
  begin
    if (wr_acc && paddr == PFS_OFF_TABLE_WRITE)
      latch_q[offs_q[5:0]] <= pwdata[23:0];
  end

  always_comb
  begin
    cpu_stall = stall_q;
    prdata = prdata_q;
    pready = pready_q;
    pslverr = pslverr_q;
    flash_out = fl_q;
  end

  property p_start_stall;
    @(posedge pclk) disable iff (!presetn)
    $rose(ctl_q[PFS_BIT_START]) |-> cpu_stall;
  endproperty
  a_start_stall: assert property (p_start_stall) else $error("start without stall");

  property p_self_clear;
    @(posedge pclk) disable iff (!presetn)
    $fell(cpu_stall) |-> !ctl_q[PFS_BIT_START];
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("start bit not cleared");

  property p_no_key;
    @(posedge pclk) disable iff (!presetn)
    (start_req && !armed) |=> (st_q == PFS_IDLE && refused_q);
  endproperty
  a_no_key: assert property (p_no_key) else $error("unkeyed start accepted");

  property p_keyed;
    @(posedge pclk) disable iff (!presetn)
    (st_q == PFS_IDLE && $past(st_q) == PFS_IDLE && st_d != PFS_IDLE) |-> armed;
  endproperty
  a_keyed: assert property (p_keyed) else $error("cycle started without keys");

  property p_prog_erased;
    @(posedge pclk) disable iff (!presetn)
    (st_q == PFS_PROG) |-> (erased_q[offs_q[8:6]] || cnt_q == 16'h0000);
  endproperty
  a_prog_erased: assert property (p_prog_erased) else $error("row program into unerased page");

  property p_erase_all;
    @(posedge pclk) disable iff (!presetn)
    (st_q == PFS_ERASE && cnt_q == 16'h0001) |=> (erased_q == 8'hFF && !cpu_stall);
  endproperty
  a_erase_all: assert property (p_erase_all) else $error("erase did not clear page");

  property p_erase_addr;
    @(posedge pclk) disable iff (!presetn)
    (flash_out.req && flash_out.erase) |-> (flash_out.addr[8:0] == 9'h000);
  endproperty
  a_erase_addr: assert property (p_erase_addr) else $error("erase not page aligned");

  property p_prog_done;
    @(posedge pclk) disable iff (!presetn)
    (st_q == PFS_PROG && cnt_q == 16'h0001) |=> (lvalid_q == 64'h0);
  endproperty
  a_prog_done: assert property (p_prog_done) else $error("latches not released");
endmodule

// *** tb/pfs_flash_model.sv ***
`timescale 1ns/100ps
// stands in for the flash array and logs every command that the sequencer issues
module pfs_flash_model
  import pfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input pfs_pkg::pfs_flash_s flash_out,
  output int erase_cnt
);
  logic [23:0] words[$];
  logic [15:0] addrs[$];
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      erase_cnt <= 0;
    else if (flash_out.req === 1'b1 && flash_out.erase === 1'b1)
    begin
      erase_cnt <= erase_cnt + 1;
      addrs.push_back(flash_out.addr);
    end
    else if (flash_out.req === 1'b1)
    begin
      words.push_back(flash_out.data);
      addrs.push_back(flash_out.addr);
    end
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import pfs_pkg::*;
  localparam int ERASE_N = 8;
  localparam int PROG_N = 70;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpu_stall;
  pfs_flash_s flash_out;
  int erase_cnt;
  int fails = 0;
  int checked = 0;
  int stall_n = 0;
  logic [31:0] rd;
  logic [31:0] d;
  logic er;
  logic [23:0] exp_q[$];
  logic [6:0] page;
  logic [7:0] rows;
  pfs_sequencer #(.ERASE_CYCLES(ERASE_N), .PROGRAM_CYCLES(PROG_N)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall), .flash_out(flash_out));
  pfs_flash_model FM (.pclk(pclk), .presetn(presetn), .flash_out(flash_out), .erase_cnt(erase_cnt));
  initial
  begin
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (cpu_stall === 1'b1)
      stall_n <= stall_n + 1;
  task automatic end_sim;
    $display("counts checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flash(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // the request stands until pready is seen high at a rising edge; data and error are taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dv, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dv;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      fails++;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dv);
    apb(1'b1, a, dv, rd, er);
  endtask
  task automatic unlock;
    wr(PFS_OFF_KEY, {24'h0, PFS_KEY_FIRST});
    wr(PFS_OFF_KEY, {24'h0, PFS_KEY_SECOND});
  endtask
  // n is the expected stall length, zero for a start that must be ignored
  task automatic go(input logic [31:0] c, input int n);
    stall_n = 0;
    wr(PFS_OFF_CONTROL, c);
    for (int i = 0; i < 3 && cpu_stall !== 1'b1; i++)
      @(negedge pclk);
    for (int i = 0; i < 2000 && cpu_stall !== 1'b0; i++)
      @(negedge pclk);
    chk_reg(stall_n, n);
    apb(1'b0, PFS_OFF_CONTROL, 32'h0, rd, er);
    chk_reg(rd & 32'h8000, 32'h0);
    apb(1'b0, PFS_OFF_STATUS, 32'h0, rd, er);
    chk_reg(rd & 32'h200, (n == 0) ? 32'h200 : 32'h0);
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'hEE58));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, PFS_OFF_CONTROL, 32'h0, rd, er);
    chk_reg(rd, {16'h0, PFS_CONTROL_RESET});
    apb(1'b0, PFS_OFF_STATUS, 32'h0, rd, er);
    chk_reg(rd, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0, rd, er);
    chk_reg({31'h0, er}, 32'h1);
    wr(PFS_OFF_STATUS, 32'hFFFF);
    chk_reg({31'h0, er}, 32'h1);
    $display("test reset_map done");
    wr(PFS_OFF_CONTROL, 32'h4042);
    go(32'hC042, 0);
    wr(PFS_OFF_KEY, {24'h0, PFS_KEY_FIRST});
    wr(PFS_OFF_PAGE, 32'h1);
    wr(PFS_OFF_KEY, {24'h0, PFS_KEY_SECOND});
    go(32'hC042, 0);
    chk_reg(erase_cnt, 0);
    $display("test refused_start done");
    page = 7'($urandom);
    wr(PFS_OFF_CONTROL, 32'h4042);
    wr(PFS_OFF_PAGE, 32'($urandom) & 32'hFF);
    wr(PFS_OFF_OFFSET, {16'h0, page, 9'($urandom)});
    wr(PFS_OFF_TABLE_WRITE, 32'h0);
    unlock();
    go(32'hC042, ERASE_N);
    chk_reg(erase_cnt, 1);
    chk_flash({8'h0, FM.addrs[0]}, {8'h0, page, 9'h000});
    FM.addrs.delete();
    rows = 8'hFF;
    chk_reg(rd & 32'hFF, {24'h0, rows});
    $display("test page_erase done");
    for (int r = 0; r < 8; r++)
    begin
      wr(PFS_OFF_PAGE, r);
      for (int i = 0; i < 64; i++)
      begin
        d = $urandom;
        exp_q.push_back(d[23:0]);
        wr(PFS_OFF_OFFSET, {16'h0, page, 3'(r), 6'(i)});
        wr(PFS_OFF_TABLE_WRITE, d);
      end
      wr(PFS_OFF_CONTROL, 32'h4001);
      unlock();
      go(32'hC001, PROG_N);
      rows[r] = 1'b0;
      chk_reg(rd & 32'hFF, {24'h0, rows});
      chk_reg(FM.words.size(), 64);
      for (int i = 0; i < 64 && i < FM.words.size(); i++)
      begin
        chk_flash(FM.words[i], exp_q[i]);
        chk_flash({8'h0, FM.addrs[i]}, {8'h0, page, 3'(r), 6'(i)});
      end
      FM.words.delete();
      FM.addrs.delete();
      exp_q.delete();
    end
    $display("test row_program done");
    wr(PFS_OFF_OFFSET, {16'h0, page, 9'h000});
    unlock();
    go(32'hC001, 0);
    chk_reg(FM.words.size(), 0);
    $display("test reprogram_refused done");
    end_sim();
  end
endmodule
